// file: design/pcu_cfg.svh
// Constants of the position compare unit: register indices, masks, reset values, timing.
// Assumes the including file needs only these macros; no logic lives here.
`ifndef PCU_CFG_SVH
`define PCU_CFG_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define PCU_IDX_START     14'h0570
`define PCU_IDX_AXIS      14'h0572
`define PCU_IDX_REMAIN    14'h0574
`define PCU_IDX_CTRL      14'h0576
`define PCU_IDX_IRQ_STAT  14'h05f0
`define PCU_IDX_IRQ_MASK  14'h05f1

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define PCU_CTRL_RESET    32'h00640010
`define PCU_CTRL_WMASK    32'h0fff313f
`define PCU_AXIS_RESET    32'h00000000
`define PCU_REMAIN_RESET  16'h0001
`define PCU_START_RESET   16'h0000

// ----------------------------------------
// Control field codes and bit positions
// ----------------------------------------
`define PCU_RUN_BIT       0
`define PCU_CYCLE_BIT     1
`define PCU_CAPT_BIT      2
`define PCU_SRC_LO        4
`define PCU_SRC_HI        7
`define PCU_SRC_CAPT      2'h0
`define PCU_SRC_AUX       2'h1
`define PCU_SRC_PULSE     2'h2
`define PCU_SRC_MOTOR     4'h3

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define PCU_EV_HIT        0
`define PCU_EV_DONE       1
`define PCU_EV_REFUSE     2
`define PCU_EV_W          3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCU_CLK_NS        8
`define PCU_MS_NS         1000000

`endif

// file: design/pcu_pkg.sv
// Types of the position compare unit: control word layout, position bundle, engine states.
// Assumes pcu_cfg.svh supplies the numeric constants used by the design.
package pcu_pkg;

  // ----------------------------------------
  // Control word layout
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  rsv_top;
    logic [11:0] pulse_len;
    logic [1:0]  rsv_mid;
    logic [1:0]  aux_bits;
    logic [3:0]  polarity;
    logic [3:0]  source;
    logic [3:0]  func;
  } pcu_ctrl_t;

  // ----------------------------------------
  // Position feedback bundle
  // ----------------------------------------
  typedef struct packed {
    logic signed [31:0] capture_axis;
    logic signed [31:0] aux_scale;
    logic signed [31:0] pulse_cmd;
    logic signed [31:0] motor_enc;
  } pcu_pos_t;

  // ----------------------------------------
  // Compare engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PCU_ST_IDLE = 3'b001,
    PCU_ST_LOAD = 3'b010,
    PCU_ST_CMP  = 3'b100
  } pcu_state_t;

endpackage : pcu_pkg

// file: design/pcu_top.sv
// Position compare unit: APB registers, compare engine over an external point array,
// timed output pulse and hand-over to the capture function.
// Assumes positions, array data and capture state come from logic on mclk.
//
// How it works
// - Axis position is signed 32-bit; writes accepted only while compare is off.
// - Writing source 3 loads axis position from motor encoder feedback.
// - Count is read-write when off, read-only remaining points when on.
// - Each compared point decrements remaining count; zero means run complete.
// - Control word is 32 bits, resets to 00640010h, legal bits within 0FFF313Fh.
// - Writing start bit 1 with remaining count above zero starts comparing.
// - Non-cyclic run clears the start bit itself when count reaches zero.
// - Start with zero count does not start and start bit reads zero.
// - While running only writing start 0 counts, and it stops the run.
// - Cycle mode reloads count, restarts at first point, start bit stays set.
// - Capture hand-over bit enables capture and reloads its count after last point, unless capture already runs.
// - Source field picks capture axis, aux scale, pulse command or motor encoder.
// - Polarity field 0 gives normally open, 1 normally closed output.
// - Output pulse lasts the pulse-length field in milliseconds.
// - Reading starts at the array start index, default 0, set only when off.
`timescale 1ns/1ps
`include "pcu_cfg.svh"

module pcu_top #(
  parameter int MS_CYCLES = `PCU_MS_NS / `PCU_CLK_NS
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire pcu_pkg::pcu_pos_t pos,
  output logic      [15:0]       array_index,
  input  wire logic signed [31:0] array_data,
  input  wire logic              capture_enabled,
  output logic                   capture_enable_set,
  output logic                   capture_count_load,
  output logic                   compare_out,
  output logic                   irq
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  pcu_pkg::pcu_ctrl_t  ctrl;
  pcu_pkg::pcu_state_t state;
  logic signed [31:0]  axis_pos;
  logic signed [31:0]  target;
  logic        [15:0]  remain;
  logic        [15:0]  plan;
  logic        [15:0]  start_idx;
  logic        [11:0]  pulse_ms;
  logic        [16:0]  prescale;
  logic [`PCU_EV_W-1:0] irq_stat;
  logic [`PCU_EV_W-1:0] irq_mask;
  logic [`PCU_EV_W-1:0] events;
  logic signed [31:0]  sel_pos;
  logic                run;
  logic                next_run;
  logic                cycle_on;
  logic                hit;
  logic                last;
  logic                start;
  logic                refuse;
  logic                wr;
  logic                rd_setup;
  logic                mapped;
  logic [13:0]         idx;
  logic                wr_ctrl;
  logic                wr_axis;
  logic                wr_remain;
  logic                wr_start;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Zero wait states keep the slave simple; every access ends in its first access cycle
  assign idx       = paddr[15:2];
  assign mapped    = (idx == `PCU_IDX_START) || (idx == `PCU_IDX_AXIS) || (idx == `PCU_IDX_REMAIN)
                  || (idx == `PCU_IDX_CTRL) || (idx == `PCU_IDX_IRQ_STAT) || (idx == `PCU_IDX_IRQ_MASK);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign wr        = psel && penable && pwrite && mapped;
  assign rd_setup  = psel && !penable && !pwrite;
  assign wr_ctrl   = wr && (idx == `PCU_IDX_CTRL);
  assign wr_axis   = wr && (idx == `PCU_IDX_AXIS);
  assign wr_remain = wr && (idx == `PCU_IDX_REMAIN);
  assign wr_start  = wr && (idx == `PCU_IDX_START);

  // Source selection
  always_comb begin
    case (ctrl.source[1:0])
      `PCU_SRC_CAPT:  sel_pos = pos.capture_axis;
      `PCU_SRC_AUX:   sel_pos = pos.aux_scale;
      `PCU_SRC_PULSE: sel_pos = pos.pulse_cmd;
      default:        sel_pos = pos.motor_enc;
    endcase
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  assign run      = ctrl.func[`PCU_RUN_BIT];
  assign cycle_on = ctrl.func[`PCU_CYCLE_BIT];
  assign hit      = (state == pcu_pkg::PCU_ST_CMP) && (sel_pos == target);
  assign last     = hit && (remain == 16'h0001);

  // Stop and completion win over a repeated start; a second 1 simply leaves the run going
  always_comb begin
    next_run = run;
    refuse   = 1'b0;
    if (!run) begin
      if (wr_ctrl && pwdata[`PCU_RUN_BIT]) begin
        next_run = (remain != 16'h0000);
        refuse   = (remain == 16'h0000);
      end
    end else if ((wr_ctrl && !pwdata[`PCU_RUN_BIT]) || (last && !cycle_on)) begin
      next_run = 1'b0;
    end
  end
  assign start = !run && next_run;

  // Control word; bit 3 is stored only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `PCU_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata & `PCU_CTRL_WMASK;
      end
      ctrl.func[`PCU_RUN_BIT] <= next_run;
    end
  end

  // Axis position: follows the selected source while running
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      axis_pos <= `PCU_AXIS_RESET;
    end else if (wr_ctrl && (pwdata[`PCU_SRC_HI:`PCU_SRC_LO] == `PCU_SRC_MOTOR)) begin
      axis_pos <= pos.motor_enc;
    end else if (run) begin
      axis_pos <= sel_pos;
    end else if (wr_axis) begin
      axis_pos <= pwdata;
    end
  end

  // Remaining and planned count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      remain <= `PCU_REMAIN_RESET;
      plan   <= `PCU_REMAIN_RESET;
    end else if (!run && wr_remain) begin
      remain <= pwdata[15:0];
      plan   <= pwdata[15:0];
    end else if (last && cycle_on) begin
      remain <= plan;
    end else if (hit) begin
      remain <= remain - 16'h0001;
    end
  end

  // Array start index
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_idx <= `PCU_START_RESET;
    end else if (!run && wr_start) begin
      start_idx <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Compare engine
  // ----------------------------------------
  // One load cycle lets the array answer the new index before comparing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= pcu_pkg::PCU_ST_IDLE;
      array_index <= 16'h0000;
      target      <= 32'sh00000000;
    end else begin
      case (state)
        pcu_pkg::PCU_ST_IDLE: begin
          if (start) begin
            array_index <= start_idx;
            state       <= pcu_pkg::PCU_ST_LOAD;
          end
        end
        pcu_pkg::PCU_ST_LOAD: begin
          target <= array_data;
          state  <= next_run ? pcu_pkg::PCU_ST_CMP : pcu_pkg::PCU_ST_IDLE;
        end
        pcu_pkg::PCU_ST_CMP: begin
          if (!next_run) begin
            state <= pcu_pkg::PCU_ST_IDLE;
          end else if (hit) begin
            array_index <= (last && cycle_on) ? start_idx : array_index + 16'h0001;
            state       <= pcu_pkg::PCU_ST_LOAD;
          end
        end
        default: state <= pcu_pkg::PCU_ST_IDLE;
      endcase
    end
  end

  // Capture hand-over pulses; skipped when capture already runs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      capture_enable_set <= 1'b0;
      capture_count_load <= 1'b0;
    end else begin
      capture_enable_set <= last && ctrl.func[`PCU_CAPT_BIT] && !capture_enabled;
      capture_count_load <= last && ctrl.func[`PCU_CAPT_BIT] && !capture_enabled;
    end
  end

  // ----------------------------------------
  // Output pulse
  // ----------------------------------------
  // A hit during a pulse restarts it; length 0 gives no pulse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_ms <= 12'h000;
      prescale <= 17'h00000;
    end else if (hit) begin
      pulse_ms <= ctrl.pulse_len;
      prescale <= 17'h00000;
    end else if (pulse_ms != 12'h000) begin
      if (prescale == 17'(MS_CYCLES - 1)) begin
        prescale <= 17'h00000;
        pulse_ms <= pulse_ms - 12'h001;
      end else begin
        prescale <= prescale + 17'h00001;
      end
    end
  end

  // Polarity flips the idle level of the output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      compare_out <= 1'b0;
    end else begin
      compare_out <= (pulse_ms != 12'h000) ^ ctrl.polarity[0];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign events[`PCU_EV_HIT]    = hit;
  assign events[`PCU_EV_DONE]   = last && !cycle_on;
  assign events[`PCU_EV_REFUSE] = refuse;

  // Sticky status; a new event beats a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && (idx == `PCU_IDX_IRQ_STAT)) ? pwdata[`PCU_EV_W-1:0] : '0)) | events;
      if (wr && (idx == `PCU_IDX_IRQ_MASK)) begin
        irq_mask <= pwdata[`PCU_EV_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (idx)
        `PCU_IDX_START:    prdata <= {16'h0000, start_idx};
        `PCU_IDX_AXIS:     prdata <= axis_pos;
        `PCU_IDX_REMAIN:   prdata <= {16'h0000, remain};
        `PCU_IDX_CTRL:     prdata <= ctrl;
        `PCU_IDX_IRQ_STAT: prdata <= {29'h00000000, irq_stat};
        `PCU_IDX_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_AXIS_LOCK: assert property (@(posedge mclk) disable iff (!reset_n)
    (run && wr_axis && !wr_ctrl) |=> (axis_pos == $past(sel_pos)))
    else $error("axis position written while compare runs");

  AST_ENC_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_ctrl && pwdata[7:4] == 4'h3) |=> (axis_pos == $past(pos.motor_enc)))
    else $error("motor encoder position not loaded");

  AST_REM_RO: assert property (@(posedge mclk) disable iff (!reset_n)
    (run && wr_remain && !hit) |=> (remain == $past(remain)))
    else $error("remaining count written while running");

  AST_REM_DEC: assert property (@(posedge mclk) disable iff (!reset_n)
    (hit && remain > 16'h0001) |=> (remain == $past(remain) - 16'h0001))
    else $error("remaining count not decremented");

  AST_START: assert property (@(posedge mclk) disable iff (!reset_n)
    (!run && wr_ctrl && pwdata[0] && remain != 16'h0000) |=> (run && state == pcu_pkg::PCU_ST_LOAD))
    else $error("compare did not start");

  AST_DONE: assert property (@(posedge mclk) disable iff (!reset_n)
    (last && !cycle_on) |=> (!run && state == pcu_pkg::PCU_ST_IDLE))
    else $error("start bit not cleared at completion");

  AST_NO_START: assert property (@(posedge mclk) disable iff (!reset_n)
    (!run && wr_ctrl && pwdata[0] && remain == 16'h0000) |=> !run [*2])
    else $error("started with zero count");

  AST_REFUSE: assert property (@(posedge mclk) disable iff (!reset_n)
    (run && wr_ctrl && pwdata[0] && !(last && !cycle_on)) |=> run)
    else $error("running compare stopped by a write of one");

  AST_CYCLE: assert property (@(posedge mclk) disable iff (!reset_n)
    (last && cycle_on && !wr_ctrl && !wr_start) |=> (run && remain == $past(plan) && array_index == start_idx))
    else $error("cycle mode did not restart");

  AST_CAPT: assert property (@(posedge mclk) disable iff (!reset_n)
    (last && ctrl.func[2] && !capture_enabled) |=> (capture_enable_set && capture_count_load) ##1 !capture_enable_set)
    else $error("capture hand-over missing");

  AST_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
    (hit && ctrl.pulse_len != 12'h000) |=> (pulse_ms == $past(ctrl.pulse_len)) ##2 (compare_out != ctrl.polarity[0]))
    else $error("output pulse not started");

  AST_START_IDX: assert property (@(posedge mclk) disable iff (!reset_n)
    start |=> (array_index == $past(start_idx)))
    else $error("run did not begin at the start index");

  AST_START_LOCK: assert property (@(posedge mclk) disable iff (!reset_n)
    (run && wr_start) |=> (start_idx == $past(start_idx)))
    else $error("start index written while running");

  AST_CMP_LOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    (state == pcu_pkg::PCU_ST_LOAD && next_run) |=> (state == pcu_pkg::PCU_ST_CMP && target == $past(array_data)))
    else $error("point not loaded before compare");

  AST_HIT_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    hit |=> irq_stat[`PCU_EV_HIT])
    else $error("hit status not set");

  AST_REFUSE_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    refuse |=> irq_stat[`PCU_EV_REFUSE])
    else $error("refused start not flagged");

  AST_CTRL_MASK: assert property (@(posedge mclk) disable iff (!reset_n)
    ((ctrl & ~`PCU_CTRL_WMASK) == 32'h00000000))
    else $error("control word holds bits outside its legal range");

  AST_CAPT_SKIP: assert property (@(posedge mclk) disable iff (!reset_n)
    capture_enabled |=> (!capture_enable_set && !capture_count_load))
    else $error("hand-over fired while capture was on");

  AST_OUT_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
    (pulse_ms == 12'h000) |=> (compare_out == $past(ctrl.polarity[0])))
    else $error("idle output level does not follow polarity");

  AST_OUT_ACTIVE: assert property (@(posedge mclk) disable iff (!reset_n)
    (pulse_ms != 12'h000) |=> (compare_out != $past(ctrl.polarity[0])))
    else $error("active output level does not follow polarity");

  AST_PULSE_TICK: assert property (@(posedge mclk) disable iff (!reset_n)
    (pulse_ms != 12'h000 && !hit && prescale == 17'(MS_CYCLES - 1)) |=> (pulse_ms == $past(pulse_ms) - 12'h001))
    else $error("pulse length not counted down per millisecond");

endmodule : pcu_top

// file: testbench/pcu_partner.sv
// Far-side model: position feedback sources, point array and capture function enable.
// Assumes the bench sets the base position; everything runs on mclk.
`timescale 1ns/1ps

module pcu_partner #(
  parameter int N_PTS = 16  // Small table, far under the shared entry limit
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic signed [31:0] cur,
  input  wire logic [15:0]        array_index,
  input  wire logic               capture_enable_set,
  output pcu_pkg::pcu_pos_t       pos,
  output logic signed [31:0]      array_data,
  output logic                    capture_enabled
);
  // Each source sits at its own offset, so a wrong source choice misses every point
  assign pos.capture_axis = cur;
  assign pos.aux_scale    = cur + 32'sd256;
  assign pos.pulse_cmd    = cur + 32'sd512;
  assign pos.motor_enc    = cur + 32'sd768;

  // Point k lies at 16*k; past the table the data is inverted so it never matches
  assign array_data = (array_index < 16'(N_PTS)) ? {12'h000, array_index, 4'h0} : ~{12'h000, array_index, 4'h0};

  // Capture function stays on once the unit hands over to it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      capture_enabled <= 1'b0;
    else if (capture_enable_set)
      capture_enabled <= 1'b1;
  end
endmodule : pcu_partner

// file: testbench/position_compare_unit_tb.sv
// Self-checking bench of the position compare unit: registers, runs, pulses, irq.
// Assumes pcu_partner as far side and APB with pready sampled at rising edges.
`timescale 1ns/1ps
`include "pcu_cfg.svh"

module position_compare_unit_tb;
  localparam int          MSC  = 4;
  localparam logic [15:0] A_ST = 16'(`PCU_IDX_START) << 2;
  localparam logic [15:0] A_AX = 16'(`PCU_IDX_AXIS) << 2;
  localparam logic [15:0] A_RM = 16'(`PCU_IDX_REMAIN) << 2;
  localparam logic [15:0] A_CT = 16'(`PCU_IDX_CTRL) << 2;
  localparam logic [15:0] A_IS = 16'(`PCU_IDX_IRQ_STAT) << 2;
  localparam logic [15:0] A_IM = 16'(`PCU_IDX_IRQ_MASK) << 2;
  logic                mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic                capture_enabled, capture_enable_set, capture_count_load, compare_out, irq;
  logic [15:0]         paddr, array_index;
  logic [31:0]         pwdata, prdata;
  logic signed [31:0]  cur, array_data;
  pcu_pkg::pcu_pos_t   pos;
  logic [32:0]         exp_q[$];
  int                  n_fail, checks_done, n_cap;

  pcu_top #(.MS_CYCLES(MSC)) u_pcu_top (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos(pos), .array_index(array_index), .array_data(array_data), .capture_enabled(capture_enabled),
    .capture_enable_set(capture_enable_set), .capture_count_load(capture_count_load),
    .compare_out(compare_out), .irq(irq));
  pcu_partner u_pcu_partner (.mclk(mclk), .reset_n(reset_n), .cur(cur), .array_index(array_index),
    .capture_enable_set(capture_enable_set), .pos(pos), .array_data(array_data),
    .capture_enabled(capture_enabled));

  // ----------------------------------------
  // Compare, bus and pulse tasks
  // ----------------------------------------
  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input logic got, input logic exp);
    cmp_bus({32'h0, got}, {32'h0, exp});
  endtask : cmp_pin

  // Request held until pready is seen high; an idle edge keeps transfers apart
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back(e);
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  // Sample a pin away from the driving edge, then realign for the next request
  task automatic pin(input logic got_sel, input logic e);
    @(negedge mclk);
    cmp_pin(got_sel ? irq : compare_out, e);
    @(posedge mclk);
  endtask : pin

  // Waits for the active level, then counts its length in clocks
  task automatic pulse(input logic p, input int len);
    int n;
    n = 0;
    while (compare_out !== ~p && n < 60) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (compare_out === ~p && n < 100) begin
      @(negedge mclk);
      n++;
    end
    cmp_bus(33'(n), 33'(len * MSC));
    @(posedge mclk);
  endtask : pulse

  task automatic summarize;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Monitor: read results against the oldest note, hand-over pulses paired
  // ----------------------------------------
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      cmp_bus({pslverr, prdata}, exp_q.pop_front());
    if (reset_n && (capture_enable_set | capture_count_load) !== 1'b0) begin
      n_cap++;
      cmp_pin(capture_count_load, capture_enable_set);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, well above the expected run length
  initial begin
    #160000;
    n_fail++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    cur = 32'sd1;
    void'($urandom(30));
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    cur <= $urandom() | 32'h1;  // Odd values never meet a point
    rd(A_CT, `PCU_CTRL_RESET);
    rd(A_AX, `PCU_AXIS_RESET);
    rd(A_RM, 32'(`PCU_REMAIN_RESET));
    rd(A_ST, 32'(`PCU_START_RESET));
    apb(1'b0, 16'h1000, 32'h0, {1'b1, 32'h0});
    wr(A_CT, 32'hfffffffe);
    rd(A_CT, 32'h0fff313e);
    pin(1'b0, 1'b1);
    wr(A_CT, 32'h00000030);
    pin(1'b0, 1'b0);
    rd(A_AX, cur + 32'sd768);
    wr(A_CT, 32'h00000020);
    wr(A_AX, 32'h80000001);  // Source is pulse command here
    rd(A_AX, 32'h80000001);
    // Start refused on a zero count, irq masked and cleared
    wr(A_IM, 32'h4);
    wr(A_RM, 32'h0);
    wr(A_CT, 32'h00010011);
    rd(A_CT, 32'h00010010);
    pin(1'b1, 1'b1);
    wr(A_IM, 32'h0);
    pin(1'b1, 1'b0);
    wr(A_IS, 32'h4);
    rd(A_IS, 32'h0);
    // Two-point run on the auxiliary scale from index 2
    wr(A_ST, 32'h2);
    wr(A_RM, 32'h2);
    wr(A_CT, 32'h00010011);
    wr(A_RM, 32'h9);
    wr(A_ST, 32'h5);
    rd(A_RM, 32'h2);
    rd(A_ST, 32'h2);
    cur <= 32'sd32 - 32'sd256;
    pulse(1'b0, 1);
    rd(A_RM, 32'h1);
    // Polarity flipped mid-run: the start bit stays, idle level and pulse invert
    wr(A_CT, 32'h00010111);
    pin(1'b0, 1'b1);
    cur <= 32'sd48 - 32'sd256;
    pulse(1'b1, 1);
    rd(A_RM, 32'h0);
    rd(A_CT, 32'h00010110);
    rd(A_IS, 32'h3);
    // A second start while running is ignored; only a stop counts
    cur <= $urandom() | 32'h1;
    wr(A_RM, 32'h3);
    wr(A_CT, 32'h00010021);
    wr(A_CT, 32'h00010021);
    rd(A_RM, 32'h3);
    wr(A_AX, 32'h00000005);  // Written while running, so the write is dropped
    rd(A_AX, cur + 32'sd512);  // Dropped write: axis keeps tracking the source
    wr(A_CT, 32'h00010010);
    wr(A_RM, 32'h5);
    rd(A_RM, 32'h5);
    // Cycle mode with capture hand-over; later hand-overs see capture on
    wr(A_ST, 32'h0);
    wr(A_RM, 32'h1);
    cur <= 32'sd0;  // Capture axis source sits right on point 0
    n_cap = 0;
    wr(A_CT, 32'h00000007);
    repeat (20) @(posedge mclk);
    cur <= $urandom() | 32'h1;
    repeat (4) @(posedge mclk);
    rd(A_RM, 32'h1);
    rd(A_CT, 32'h00000007);
    cmp_bus(33'(n_cap), 33'h1);
    wr(A_CT, 32'h00000006);
    summarize();
  end
endmodule : position_compare_unit_tb
